// ---- tpc_clk_if.sv ----
// Core to prescaler clock control
interface tpc_clk_if;
    logic [2:0] sel;  // Source select code
    logic       run;  // Counting allowed
    logic       clr;  // Prescaler clear pulse
    logic       tick; // One-cycle count enable
    modport core (output sel, output run, output clr, input tick);
    modport pre  (input sel, input run, input clr, output tick);
endinterface

// ---- tpc_core.sv ----
// Behaviour
// RULE_01: Buffered bit pairs channels onto channel-0 pin
// RULE_02: Last written pair takes over at overflow
// RULE_03: Buffered mode disables channel-1 control and pin
// RULE_04: Software writes only the inactive pair
// RULE_05: Software stops, resets, programs, then restarts
// RULE_06: Software avoids toggle-on-compare for PWM
// RULE_07: Buffered bit beats unbuffered select bit
// RULE_08: No overflow toggle gives zero duty
// RULE_09: Full-duty bit with toggle gives 100%
// RULE_10: Overflow sets flag; irq when enabled
// RULE_11: Capture/compare sets channel flag; gated irq
// RULE_12: Wait keeps counting; bus blocked; irq wakes
// RULE_13: Break halts counter until it ends
// RULE_14: Break protects flags unless clear enabled
// RULE_15: Select field picks divider or external clock
// RULE_16: External clock selection forces pin input
// RULE_17: Flag cleared by read-set then write-zero
// RULE_18: Halt bit stops counting; set at reset
// RULE_19: Counter-reset bit clears counter and prescaler
// RULE_20: Halt plus counter-reset holds zero
// RULE_21: High read latches low byte buffer
// RULE_22: Counter wraps to zero after limit
// RULE_23: Limit high write suppresses flag until low
// RULE_24: Overflow toggle beats coincident compare
// RULE_25: Full-duty change applies next period
// RULE_26: Limit resets to all ones
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`include "tpc_regs.svh"
module tpc_core (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        break_active,
    input  wire logic        break_clear_enable,
    input  wire logic        wait_mode,
    input  wire logic        external_count_clock_pin,
    output logic             ext_clk_force_input,
    input  wire logic [1:0]  chan_pin_in,
    output logic [1:0]       chan_pin_out,
    output logic [1:0]       chan_pin_oe,
    output logic             wrap_irq,
    output logic [1:0]       chan_irq,
    output logic             wake_request
);
    import tpc_pkg::*;

    // ------------------------------------------------
    // Declarations
    // ------------------------------------------------
    tpc_core_st_t st_r;        // Registered state
    tpc_core_st_t st_nxt;      // Next state
    tpc_clk_if    ck ();       // Prescaler link
    tpc_mode_t    mode [2];    // Decoded channel function
    logic [1:0]   outm;        // Channel drives its pin
    logic [1:0]   hit;         // Compare event this tick
    logic [1:0]   cap;         // Capture event this cycle
    logic         bufen;       // Pair linked
    logic         wrap;        // Overflow event this tick
    logic         prot;        // Flags frozen in break
    logic         rd_go;       // Read address phase taken
    logic         wr_go;       // Write data phase now
    logic [7:0]   ra;          // Read address
    logic [7:0]   wd;          // Write byte
    logic [7:0]   rmux;        // Read value
    logic         crst;        // Counter reset write

    tpc_prescaler i_tpc_prescaler (
        .sys_clk         (sys_clk),
        .resetn          (resetn),
        .ext_count_clock (external_count_clock_pin),
        .ck              (ck)
    );

    // ------------------------------------------------
    // Bus and shared decode
    // ------------------------------------------------
    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = {24'h000000, st_r.rdata};

    // Bus cut off in wait mode
    assign rd_go = hsel && hready && htrans[1] && !hwrite && !wait_mode; // see RULE_12
    assign wr_go = st_r.wr_pend && !wait_mode;                          // see RULE_12
    assign ra    = haddr[7:0];
    assign wd    = hwdata[7:0];
    assign crst  = wr_go && st_r.wr_addr == `TPC_OFS_STAT && wd[`TPC_ST_CRST];
    assign prot  = break_active && !break_clear_enable;                 // see RULE_14
    assign bufen = st_r.cctl[0][`TPC_CH_BUF];                           // see RULE_01

    // Counter runs unless halted or in break
    assign ck.run = !st_r.halt && !break_active; // see RULE_18 see RULE_13
    assign ck.sel = st_r.sel;
    assign ck.clr = crst;                         // see RULE_19
    assign wrap   = ck.tick && !crst && st_r.cnt == st_r.lim; // see RULE_22

    // Pin stays input while it is the source
    assign ext_clk_force_input = st_r.sel == `TPC_SEL_EXT; // see RULE_16

    // ------------------------------------------------
    // Per-channel decode
    // ------------------------------------------------
    for (genvar gi = 0; gi < 2; gi++) begin : g_ch
        logic [7:0]  c;    // Channel control
        logic [15:0] cv;   // Compare value in force
        logic        ci;   // Compare inhibit in force
        logic        rise; // Pin rising edge
        logic        fall; // Pin falling edge
        assign c = st_r.cctl[gi];
        // Buffered ch0 uses the active pair
        assign cv   = (gi == 0 && bufen) ? st_r.cval[st_r.act] : st_r.cval[gi]; // see RULE_02
        assign ci   = (gi == 0 && bufen) ? st_r.cinh[st_r.act] : st_r.cinh[gi];
        assign rise = chan_pin_in[gi] && !st_r.prev[gi];
        assign fall = !chan_pin_in[gi] && st_r.prev[gi];
        // Buffered checked before unbuffered
        always_comb begin
            if (gi == 1 && bufen) begin
                mode[gi] = mode_off;                  // see RULE_03
            end else if (c[`TPC_CH_ELH:`TPC_CH_ELL] == 2'h0) begin
                mode[gi] = mode_preset;
            end else if (gi == 0 && c[`TPC_CH_BUF]) begin
                mode[gi] = mode_buffered;             // see RULE_07
            end else if (c[`TPC_CH_UNB]) begin
                mode[gi] = mode_compare;
            end else begin
                mode[gi] = mode_capture;
            end
        end
        assign outm[gi] = mode[gi] == mode_compare || mode[gi] == mode_buffered;
        assign hit[gi]  = ck.tick && !crst && outm[gi] && st_r.cnt == cv && !ci;
        assign cap[gi]  = mode[gi] == mode_capture
                          && ((c[`TPC_CH_ELL] && rise) || (c[`TPC_CH_ELH] && fall));
        assign chan_pin_oe[gi] = outm[gi]; // see RULE_01 see RULE_03
        assign chan_irq[gi]    = mode[gi] != mode_off
                                 && c[`TPC_CH_FLAG] && c[`TPC_CH_IE]; // see RULE_11
    end

    assign chan_pin_out = st_r.pin;
    // Limit high write also masks the request
    assign wrap_irq     = st_r.flag && st_r.ie && !st_r.lim_inh; // see RULE_10 see RULE_23
    assign wake_request = wrap_irq || (|chan_irq);               // see RULE_12

    // ------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        case (ra)
            `TPC_OFS_STAT:    rmux = {st_r.flag, st_r.ie, st_r.halt, 2'h0, st_r.sel};
            `TPC_OFS_CNT_HI:  rmux = st_r.cnt[15:8];
            `TPC_OFS_CNT_LO:  rmux = st_r.lo_held ? st_r.lo_buf : st_r.cnt[7:0]; // see RULE_21
            `TPC_OFS_LIM_HI:  rmux = st_r.lim[15:8];
            `TPC_OFS_LIM_LO:  rmux = st_r.lim[7:0];
            `TPC_OFS_CH0_CTL: rmux = st_r.cctl[0];
            `TPC_OFS_CH1_CTL: rmux = bufen ? 8'h00 : st_r.cctl[1]; // see RULE_03
            `TPC_OFS_CH0_HI:  rmux = st_r.cval[0][15:8];
            `TPC_OFS_CH0_LO:  rmux = st_r.cval[0][7:0];
            `TPC_OFS_CH1_HI:  rmux = st_r.cval[1][15:8];
            `TPC_OFS_CH1_LO:  rmux = st_r.cval[1][7:0];
            default:          rmux = 8'h00;
        endcase
    end

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = chan_pin_in;

        // Address phase: latch write, serve read
        st_nxt.wr_pend = hsel && hready && htrans[1] && hwrite;
        st_nxt.wr_addr = ra;
        if (rd_go) begin
            st_nxt.rdata = rmux;
        end

        // Counter wraps after the limit
        if (crst) begin
            st_nxt.cnt = 16'h0000;              // see RULE_19 see RULE_20
        end else if (wrap) begin
            st_nxt.cnt = 16'h0000;              // see RULE_22
        end else if (ck.tick) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end

        // Low byte snapshot on high read, released on low read
        if (rd_go && ra == `TPC_OFS_CNT_HI && !st_r.lo_held) begin
            st_nxt.lo_buf  = st_r.cnt[7:0];     // see RULE_21
            st_nxt.lo_held = 1'b1;
        end else if (rd_go && ra == `TPC_OFS_CNT_LO) begin
            st_nxt.lo_held = 1'b0;
        end

        // Status write; flag only clears
        if (wr_go && st_r.wr_addr == `TPC_OFS_STAT) begin
            st_nxt.ie   = wd[`TPC_ST_IE];
            st_nxt.halt = wd[`TPC_ST_HALT];      // see RULE_18
            st_nxt.sel  = wd[`TPC_ST_SEL];       // see RULE_15
            if (!wd[`TPC_ST_FLAG] && st_r.arm && !prot) begin
                st_nxt.flag = 1'b0;              // see RULE_17
            end
            if (!prot) begin
                st_nxt.arm = 1'b0;
            end
        end
        // Arm the clear; frozen in protected break
        if (rd_go && ra == `TPC_OFS_STAT && st_r.flag && !prot) begin
            st_nxt.arm = 1'b1;                   // see RULE_14
        end
        // Fresh overflow voids a clear
        if (wrap && !st_r.lim_inh) begin
            st_nxt.flag = 1'b1;                  // see RULE_10 see RULE_23
            st_nxt.arm  = 1'b0;                  // see RULE_17
        end

        // Limit bytes; high write holds off the flag
        if (wr_go && st_r.wr_addr == `TPC_OFS_LIM_HI) begin
            st_nxt.lim[15:8] = wd;
            st_nxt.lim_inh   = 1'b1;             // see RULE_23
        end
        if (wr_go && st_r.wr_addr == `TPC_OFS_LIM_LO) begin
            st_nxt.lim[7:0] = wd;
            st_nxt.lim_inh  = 1'b0;
        end

        // Pair switches at overflow; unbuffered forces pair 0
        if (wrap) begin
            st_nxt.act = bufen ? st_r.last : 1'b0; // see RULE_02
        end
        if (!bufen) begin
            st_nxt.act = 1'b0;
        end

        // Per channel updates
        for (int i = 0; i < 2; i++) begin
            // Control write; buffer bit on ch0 only
            if (wr_go && st_r.wr_addr == (i == 0 ? `TPC_OFS_CH0_CTL : `TPC_OFS_CH1_CTL)
                    && !(i == 1 && bufen)) begin
                st_nxt.cctl[i][6:0] = wd[6:0];
                if (i == 1) begin
                    st_nxt.cctl[i][`TPC_CH_BUF] = 1'b0;
                end
                if (!wd[`TPC_CH_FLAG] && st_r.carm[i] && !prot) begin
                    st_nxt.cctl[i][`TPC_CH_FLAG] = 1'b0; // see RULE_11 see RULE_14
                end
                if (!prot) begin
                    st_nxt.carm[i] = 1'b0;
                end
            end
            if (rd_go && ra == (i == 0 ? `TPC_OFS_CH0_CTL : `TPC_OFS_CH1_CTL)
                    && st_r.cctl[i][`TPC_CH_FLAG] && !prot) begin
                st_nxt.carm[i] = 1'b1;
            end

            // High value byte holds off compares
            if (wr_go && st_r.wr_addr == (i == 0 ? `TPC_OFS_CH0_HI : `TPC_OFS_CH1_HI)) begin
                st_nxt.cval[i][15:8] = wd;
                st_nxt.cinh[i] = 1'b1;
            end
            if (wr_go && st_r.wr_addr == (i == 0 ? `TPC_OFS_CH0_LO : `TPC_OFS_CH1_LO)) begin
                st_nxt.cval[i][7:0] = wd;
                st_nxt.cinh[i] = 1'b0;
                st_nxt.last = i[0];              // see RULE_02
            end

            // Capture latches the counter
            if (cap[i]) begin
                st_nxt.cval[i] = st_r.cnt;
            end

            // Event flag; set wins over a clear
            if (hit[i] || cap[i]) begin
                st_nxt.cctl[i][`TPC_CH_FLAG] = 1'b1; // see RULE_11
                st_nxt.carm[i] = 1'b0;
            end

            // Output level
            case (mode[i])
                mode_preset: begin
                    st_nxt.pin[i] = !st_r.cctl[i][`TPC_CH_UNB];
                end
                mode_compare, mode_buffered: begin
                    if (wrap && st_r.cctl[i][`TPC_CH_TOV]) begin
                        // Overflow wins; full duty sampled per period
                        st_nxt.maxe[i] = st_r.cctl[i][`TPC_CH_MAX]; // see RULE_25
                        if (st_r.cctl[i][`TPC_CH_MAX]) begin
                            st_nxt.pin[i] = !st_r.cctl[i][`TPC_CH_ELL]; // see RULE_09
                        end else begin
                            st_nxt.pin[i] = !st_r.pin[i]; // see RULE_24
                        end
                    end else if (hit[i] && !(st_r.maxe[i] && st_r.cctl[i][`TPC_CH_TOV])) begin
                        // Full duty with wrap toggle holds the level
                        case (st_r.cctl[i][`TPC_CH_ELH:`TPC_CH_ELL])
                            2'h1:    st_nxt.pin[i] = !st_r.pin[i];
                            2'h2:    st_nxt.pin[i] = 1'b0; // see RULE_08
                            default: st_nxt.pin[i] = 1'b1;
                        endcase
                    end
                    if (wrap && !st_r.cctl[i][`TPC_CH_TOV]) begin
                        st_nxt.maxe[i] = 1'b0;
                    end
                end
                default: begin
                    st_nxt.maxe[i] = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // State register
    // ------------------------------------------------
    // Limit all ones, halted, everything else clear
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_r      <= '0;
            st_r.halt <= 1'b1;          // see RULE_18
            st_r.lim  <= `TPC_LIM_RST;  // see RULE_26
        end else begin
            st_r <= st_nxt;
        end
    end

    // Only byte lane 0 is used
    logic unused_ok;
    assign unused_ok = |{hsize, haddr[31:8], hwdata[31:8]};
endmodule

// ---- tpc_core_chk.sv ----
`include "tpc_regs.svh"
module tpc_core_chk (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        wait_mode,
    input wire logic        ext_clk_force_input,
    input wire logic [1:0]  chan_pin_oe,
    input wire logic        wrap_irq,
    input wire logic [1:0]  chan_irq,
    input wire logic        wake_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wr_r;  // Write now in data phase
    logic       rd_r;  // Read now in data phase
    logic [7:0] adr_r; // Its byte offset
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Taken transfers; wait mode drops them
    always_ff @(posedge sys_clk) begin
        wr_r  <= resetn && hsel && hready && htrans[1] && hwrite && !wait_mode;
        rd_r  <= resetn && hsel && hready && htrans[1] && !hwrite && !wait_mode;
        adr_r <= haddr[7:0];
    end
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not okay");
    a_wake_any: assert property (wake_request == (wrap_irq || (|chan_irq)))
        else $error("wake mismatch");
    a_ext_on: assert property (wr_r && adr_r == `TPC_OFS_STAT && hwdata[2:0] == 3'h7
        |=> ext_clk_force_input) else $error("pin not forced");
    a_ext_off: assert property (wr_r && adr_r == `TPC_OFS_STAT && hwdata[2:0] != 3'h7
        |=> !ext_clk_force_input) else $error("pin forced");
    a_reset_quiet: assert property ($rose(resetn) |-> hrdata == 32'h0
        && chan_pin_oe == 2'h0 && !wrap_irq && chan_irq == 2'h0 && !ext_clk_force_input)
        else $error("not quiet");
    a_crst_zero: assert property (rd_r && adr_r == `TPC_OFS_STAT |-> !hrdata[4])
        else $error("reset bit set");
    a_buf_pair: assert property (wr_r && adr_r == `TPC_OFS_CH0_CTL && hwdata[5]
        && hwdata[3:2] != 2'h0 |=> chan_pin_oe == 2'h1) else $error("pair wrong");
    a_chirq_off: assert property (wr_r && adr_r == `TPC_OFS_CH0_CTL && !hwdata[6]
        |=> !chan_irq[0]) else $error("chan irq on");
    a_wrap_off: assert property (wr_r && adr_r == `TPC_OFS_STAT && !hwdata[6]
        |=> !wrap_irq) else $error("wrap irq on");
endmodule
bind tpc_core tpc_core_chk i_tpc_core_chk (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .wait_mode, .ext_clk_force_input,
    .chan_pin_oe, .wrap_irq, .chan_irq, .wake_request);

// ---- tpc_pins_model.sv ----
module tpc_pins_model (
    input  wire logic       sys_clk,
    input  wire logic       ext_en,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    output logic            ext_clk,
    output logic [1:0]      pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] far_lvl = 2'h0; // Far-side drive
    // Off-grid oscillator; low when unused
    initial ext_clk = 1'h0;
    always #37 ext_clk = ext_en ? ~ext_clk : 1'h0;
    always @(posedge sys_clk) far_lvl <= far_lvl + 2'h1;
    // Released pins show the far side
    assign pin_in = (pin_out & pin_oe) | (far_lvl & ~pin_oe);
endmodule

// ---- tpc_pkg.sv ----
package tpc_pkg;
    // Decoded function of one channel
    typedef enum logic [2:0] {
        mode_off,
        mode_preset,
        mode_capture,
        mode_compare,
        mode_buffered
    } tpc_mode_t;

    // Whole state of the core
    typedef struct packed {
        logic [7:0]       rdata;
        logic             wr_pend;
        logic [7:0]       wr_addr;
        logic [15:0]      cnt;
        logic [15:0]      lim;
        logic             flag;
        logic             ie;
        logic             halt;
        logic [2:0]       sel;
        logic             arm;
        logic             lim_inh;
        logic [7:0]       lo_buf;
        logic             lo_held;
        logic [1:0][7:0]  cctl;
        logic [1:0][15:0] cval;
        logic [1:0]       carm;
        logic [1:0]       cinh;
        logic [1:0]       pin;
        logic [1:0]       prev;
        logic [1:0]       maxe;
        logic             act;
        logic             last;
    } tpc_core_st_t;

    // Whole state of the prescaler
    typedef struct packed {
        logic [5:0] div;
        logic       ext_prev;
    } tpc_pre_st_t;
endpackage

// ---- tpc_prescaler.sv ----
`include "tpc_regs.svh"
module tpc_prescaler (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic ext_count_clock,
    tpc_clk_if.pre    ck
);
    import tpc_pkg::*;

    tpc_pre_st_t st_r;   // Registered state
    tpc_pre_st_t st_nxt; // Next state
    logic [5:0]  mask;   // Low divider bits that must be all ones

    // ------------------------------------------------
    // Tick generation
    // ------------------------------------------------
    // Divide by 2**sel, or follow external edges
    always_comb begin
        st_nxt = st_r;
        mask = 6'((7'h01 << ck.sel) - 7'h01);
        st_nxt.ext_prev = ext_count_clock;
        if (ck.clr) begin
            st_nxt.div = 6'h00;
        end else if (ck.run) begin
            st_nxt.div = st_r.div + 6'h01;
        end
        if (ck.clr || !ck.run) begin
            ck.tick = 1'b0;
        end else if (ck.sel == `TPC_SEL_EXT) begin
            ck.tick = ext_count_clock && !st_r.ext_prev; // see RULE_15
        end else begin
            ck.tick = (st_r.div & mask) == mask;          // see RULE_15
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ---- tpc_regs.svh ----
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH
// ------------------------------------------------
// Register byte offsets
// ------------------------------------------------
`define TPC_OFS_STAT    8'h00
`define TPC_OFS_CNT_HI  8'h04
`define TPC_OFS_CNT_LO  8'h08
`define TPC_OFS_LIM_HI  8'h0c
`define TPC_OFS_LIM_LO  8'h10
`define TPC_OFS_CH0_CTL 8'h14
`define TPC_OFS_CH1_CTL 8'h18
`define TPC_OFS_CH0_HI  8'h1c
`define TPC_OFS_CH0_LO  8'h20
`define TPC_OFS_CH1_HI  8'h24
`define TPC_OFS_CH1_LO  8'h28
// ------------------------------------------------
// Status/control bit positions
// ------------------------------------------------
`define TPC_ST_FLAG 7
`define TPC_ST_IE   6
`define TPC_ST_HALT 5
`define TPC_ST_CRST 4
`define TPC_ST_SEL  2:0
// ------------------------------------------------
// Channel control bit positions
// ------------------------------------------------
`define TPC_CH_FLAG 7
`define TPC_CH_IE   6
`define TPC_CH_BUF  5
`define TPC_CH_UNB  4
`define TPC_CH_ELH  3
`define TPC_CH_ELL  2
`define TPC_CH_TOV  1
`define TPC_CH_MAX  0
// ------------------------------------------------
// Reset values and codes
// ------------------------------------------------
`define TPC_STAT_RST 8'h20
`define TPC_LIM_RST  16'hffff
`define TPC_SEL_EXT  3'h7
`endif

// ---- two_channel_timer_pwm_core_bench.sv ----
`include "tpc_regs.svh"
module two_channel_timer_pwm_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'h0;
    logic        resetn  = 1'h0; // Sync, active low
    logic        hsel    = 1'h0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'h0;
    logic [31:0] hwdata  = 32'h0;
    logic        brk     = 1'h0; // Debug break level
    logic        bce     = 1'h0; // Flags clearable in break
    logic        wt_md   = 1'h0; // Low-power wait
    logic        ext_en  = 1'h0; // External clock running
    logic        hreadyout, hresp, ext_clk, force_in, wrap_irq, wake;
    logic [31:0] hrdata;
    logic [1:0]  pin_in, pin_out, pin_oe, chan_irq;
    logic [7:0]  v;
    int          n_fail = 0, comparisons = 0;
    logic [7:0]  ctl [4] = '{8'h1a, 8'h18, 8'h1b, 8'h1e}; // Clear, no wrap, full, set
    logic [7:0]  dty [4] = '{8'h05, 8'h00, 8'h0a, 8'h05}; // High cycles of ten
    always #12.5 sys_clk = ~sys_clk;
    tpc_core i_tpc_core (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .break_active(brk),
        .break_clear_enable(bce), .wait_mode(wt_md), .external_count_clock_pin(ext_clk),
        .ext_clk_force_input(force_in), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
        .chan_pin_oe(pin_oe), .wrap_irq, .chan_irq, .wake_request(wake));
    tpc_pins_model i_tpc_pins_model (.sys_clk, .ext_en, .pin_out, .pin_oe, .ext_clk, .pin_in);
    // ------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------
    task automatic test_done();
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Bounded wait for hready
    task automatic rdy();
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (hreadyout !== 1'h1 && i < 64);
        if (hreadyout !== 1'h1) begin
            n_fail++;
            test_done();
        end
    endtask
    // Single word transfer; read data taken at data edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rdy();
        v = hrdata[7:0];
    endtask
    // High cycles of pin 0 in one period
    task automatic duty(input logic [7:0] e);
        logic [7:0] c;
        c = 8'h0;
        repeat (30) @(posedge sys_clk);
        repeat (10) begin
            @(posedge sys_clk);
            c = c + {7'h0, pin_out[0]};
        end
        chk(c, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(0, a, 8'h0);
        chk(v, e);
    endtask
    // Counter in a small window
    task automatic rng();
        bus(0, `TPC_OFS_CNT_LO, 8'h0);
        chk({7'h0, v >= 8'h0f && v <= 8'h13}, 8'h1);
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'h1;
        rd(`TPC_OFS_STAT, `TPC_STAT_RST);
        rd(`TPC_OFS_LIM_HI, 8'hff);
        rd(`TPC_OFS_LIM_LO, 8'hff);
        repeat (20) @(posedge sys_clk);
        rd(`TPC_OFS_CNT_LO, 8'h00);
        // Period ten, compare at four: clear, no wrap, full, set
        bus(1, `TPC_OFS_STAT, 8'h30);
        bus(1, `TPC_OFS_LIM_HI, 8'h00);
        bus(1, `TPC_OFS_LIM_LO, 8'h09);
        bus(1, `TPC_OFS_CH0_HI, 8'h00);
        bus(1, `TPC_OFS_CH0_LO, 8'h04);
        for (int k = 0; k < 4; k++) begin
            bus(1, `TPC_OFS_CH0_CTL, ctl[k]);
            bus(1, `TPC_OFS_STAT, 8'h00);
            duty(dty[k]);
        end
        // Write one keeps the flag; read, write zero clears
        bus(0, `TPC_OFS_STAT, 8'h0); chk(v & 8'h80, 8'h80);
        bus(1, `TPC_OFS_STAT, 8'he0);
        rd(`TPC_OFS_STAT, 8'he0);
        chk({7'h0, wrap_irq}, 8'h1);
        bus(1, `TPC_OFS_STAT, 8'h60);
        rd(`TPC_OFS_STAT, 8'h60);
        bus(1, `TPC_OFS_STAT, 8'h30);
        rd(`TPC_OFS_CNT_HI, 8'h00);
        rd(`TPC_OFS_CNT_LO, 8'h00);
        // Each divider for sixteen ticks, then external
        bus(1, `TPC_OFS_LIM_LO, 8'hff);
        for (int s = 0; s < 7; s++) begin
            bus(1, `TPC_OFS_STAT, 8'h10 | 8'(s));
            repeat (16 << s) @(posedge sys_clk);
            bus(1, `TPC_OFS_STAT, 8'h20 | 8'(s));
            rng();
        end
        ext_en <= 1'h1;
        bus(1, `TPC_OFS_STAT, 8'h17);
        @(posedge sys_clk);
        chk({7'h0, force_in}, 8'h1);
        repeat (48) @(posedge sys_clk);
        bus(1, `TPC_OFS_STAT, 8'h27);
        ext_en <= 1'h0;
        rng();
        // Wait mode: counting goes on, write dropped, irq wakes
        bus(1, `TPC_OFS_LIM_LO, 8'h09);
        bus(1, `TPC_OFS_STAT, 8'h50);
        wt_md <= 1'h1;
        repeat (30) @(posedge sys_clk);
        chk({7'h0, wake}, 8'h1);
        bus(1, `TPC_OFS_STAT, 8'h20);
        wt_md <= 1'h0;
        rd(`TPC_OFS_STAT, 8'hc0);
        // Break: protected clear fails, enabled clear holds
        brk <= 1'h1;
        bus(1, `TPC_OFS_STAT, 8'h40);
        rd(`TPC_OFS_STAT, 8'hc0);
        bce <= 1'h1;
        bus(1, `TPC_OFS_STAT, 8'h40);
        repeat (12) @(posedge sys_clk);
        rd(`TPC_OFS_STAT, 8'h40);
        brk <= 1'h0;
        bce <= 1'h0;
        repeat (12) @(posedge sys_clk);
        rd(`TPC_OFS_STAT, 8'hc0);
        // Buffered pair: last written pair rules
        bus(1, `TPC_OFS_CH1_CTL, 8'h1a);
        @(posedge sys_clk);
        chk({6'h0, pin_oe}, 8'h03);
        bus(1, `TPC_OFS_STAT, 8'h30);
        bus(1, `TPC_OFS_CH0_CTL, 8'h3a);
        bus(1, `TPC_OFS_STAT, 8'h00);
        chk({6'h0, pin_oe}, 8'h01);
        rd(`TPC_OFS_CH1_CTL, 8'h00);
        duty(8'h05);
        bus(1, `TPC_OFS_CH1_HI, 8'h00);
        bus(1, `TPC_OFS_CH1_LO, 8'h07);
        duty(8'h08);
        bus(1, `TPC_OFS_CH0_LO, 8'h02);
        duty(8'h03);
        test_done();
    end
endmodule
